// >>> sal_pkg.sv
// Shared constants and types for the scan-chain converter limit test controller
package sal_pkg;

  // Boundary chain shape and analogue cell positions
  localparam int unsigned SAL_CHAIN_LEN   = 198;
  localparam int unsigned SAL_IR_LEN      = 4;
  localparam int unsigned SAL_BIT_COMP    = 193;
  localparam int unsigned SAL_BIT_CONVERTER_POWER_ON   = 188;
  localparam int unsigned SAL_BIT_DAC_LO  = 177;
  localparam int unsigned SAL_BIT_EXTCH   = 176;
  localparam int unsigned SAL_BIT_HOLD    = 174;
  localparam int unsigned SAL_BIT_MUX_LO  = 165;
  localparam int unsigned SAL_BIT_PASS_GATE_ENABLE  = 161;
  localparam int unsigned SAL_BIT_COMPARATOR_PRECHARGE_N   = 160;

  // Converter line values
  localparam logic [9:0] SAL_DAC_MID      = 10'h200;
  localparam logic [7:0] SAL_MUX_IDLE     = 8'h01;
  localparam logic [7:0] SAL_MUX_RESET    = 8'h08;
  localparam logic [9:0] SAL_LOWER_RESET  = 10'h000;
  localparam logic [9:0] SAL_UPPER_RESET  = 10'h3FF;

  // Instruction codes are arbitrary defaults; set them for the target part
  localparam logic [3:0] SAL_IR_SAMPLE    = 4'h2;
  localparam logic [3:0] SAL_IR_EXTEST    = 4'h0;

  // TAP walks, sent LSB first on the test mode select line
  localparam logic [5:0] SAL_TMS_RESET    = 6'h1F;
  localparam logic [2:0] SAL_TMS_RESET_N  = 3'h6;
  localparam logic [5:0] SAL_TMS_TO_IR    = 6'h03;
  localparam logic [2:0] SAL_TMS_TO_IR_N  = 3'h4;
  localparam logic [5:0] SAL_TMS_TO_DR    = 6'h01;
  localparam logic [2:0] SAL_TMS_TO_DR_N  = 3'h3;

  // Timing
  localparam int unsigned SAL_CLK_NS      = 50;
  localparam int unsigned SAL_ENABLE_NS   = 200;
  localparam int unsigned SAL_ENABLE_CYC  = (SAL_ENABLE_NS + SAL_CLK_NS - 1) / SAL_CLK_NS;
  localparam logic [7:0]  SAL_TCK_HALF    = 8'h08;

  // Register map
  localparam logic [7:0] SAL_ADDR_CTRL    = 8'h00;
  localparam logic [7:0] SAL_ADDR_CHAN    = 8'h04;
  localparam logic [7:0] SAL_ADDR_LOWER   = 8'h08;
  localparam logic [7:0] SAL_ADDR_UPPER   = 8'h0C;
  localparam logic [7:0] SAL_ADDR_STATUS  = 8'h10;
  localparam int unsigned SAL_CTRL_START  = 0;
  localparam int unsigned SAL_ST_BUSY     = 0;
  localparam int unsigned SAL_ST_DONE     = 1;
  localparam int unsigned SAL_ST_LOW_OK   = 2;
  localparam int unsigned SAL_ST_HIGH_OK  = 3;
  localparam int unsigned SAL_ST_PASS     = 4;

  // Sequence steps
  localparam logic [3:0] SAL_SEQ_TRST     = 4'h0;
  localparam logic [3:0] SAL_SEQ_IR_SAMP  = 4'h1;
  localparam logic [3:0] SAL_SEQ_ROW1     = 4'h2;
  localparam logic [3:0] SAL_SEQ_IR_EXT   = 4'h3;
  localparam logic [3:0] SAL_SEQ_ROW2     = 4'h4;
  localparam logic [3:0] SAL_SEQ_WAIT     = 4'h5;
  localparam logic [3:0] SAL_SEQ_ROW_OFS  = 4'h3;
  localparam logic [3:0] SAL_SEQ_CHK_LOW  = 4'h9;
  localparam logic [3:0] SAL_SEQ_CHK_HIGH = 4'hE;
  localparam logic [3:0] SAL_SEQ_IDLE_ROW = 4'hF;

  typedef enum logic [1:0] {
    SAL_K_RESET = 2'h0,
    SAL_K_IR    = 2'h1,
    SAL_K_DR    = 2'h2
  } sal_kind_t;

  typedef enum logic [3:0] {
    SAL_E_IDLE  = 4'b0001,
    SAL_E_PRE   = 4'b0010,
    SAL_E_SHIFT = 4'b0100,
    SAL_E_POST  = 4'b1000
  } sal_eng_state_t;

  typedef enum logic [3:0] {
    SAL_C_IDLE  = 4'b0001,
    SAL_C_ISSUE = 4'b0010,
    SAL_C_BUSY  = 4'b0100,
    SAL_C_WAIT  = 4'b1000
  } sal_ctl_state_t;

endpackage

// >>> sal_jtag_engine.sv
// TAP walker: makes the test clock and shifts one instruction or data load
`timescale 1ns/100ps
`default_nettype none
module sal_jtag_engine #(
  parameter int unsigned WIDTH = sal_pkg::SAL_CHAIN_LEN,
  parameter logic [7:0]  HALF  = sal_pkg::SAL_TCK_HALF
) (
  input  wire logic               clk_i,
  input  wire logic               reset_i,
  input  wire logic               start_i,
  input  wire sal_pkg::sal_kind_t kind_i,
  input  wire logic [7:0]         len_i,
  input  wire logic [WIDTH-1:0]   data_i,
  output logic                    busy_o,
  output logic                    done_o,
  output logic [WIDTH-1:0]        data_o,
  output logic                    tck_o,
  output logic                    tms_o,
  output logic                    tdi_o,
  input  wire logic               tdo_i
);
  import sal_pkg::*;

  sal_eng_state_t   st_q, st_d;
  sal_kind_t        kind_q, kind_d;
  logic [7:0]       div_q, div_d;
  logic [7:0]       cnt_q, cnt_d;
  logic [7:0]       len_q, len_d;
  logic [5:0]       pre_q, pre_d;
  logic [WIDTH-1:0] sr_q, sr_d;
  logic             tck_q, tck_d;
  logic             tms_q, tms_d;
  logic             tdi_q, tdi_d;
  logic             cap_q, cap_d;
  logic             done_q, done_d;
  logic             s1_q, s2_q, s3_q;
  logic             tdo_f_q, tdo_f_d;
  logic             tick, rise, fall;

  always_comb
  begin
    st_d    = st_q;
    kind_d  = kind_q;
    div_d   = div_q;
    cnt_d   = cnt_q;
    len_d   = len_q;
    pre_d   = pre_q;
    sr_d    = sr_q;
    tck_d   = tck_q;
    tms_d   = tms_q;
    tdi_d   = tdi_q;
    cap_d   = cap_q;
    done_d  = 1'b0;
    // Pin input counts only once the last two stages agree
    tdo_f_d = (s2_q == s3_q) ? s3_q : tdo_f_q;
    tick    = (div_q == HALF - 8'h01);
    rise    = tick & ~tck_q;
    fall    = tick & tck_q;
    if (st_q != SAL_E_IDLE)
    begin
      div_d = tick ? 8'h00 : div_q + 8'h01;
      if (tick)
        tck_d = ~tck_q;
      // Device shifts on the rising edge, so the sample is taken there
      if (rise && cap_q)
        sr_d = {tdo_f_q, sr_q[WIDTH-1:1]};
    end
    case (st_q)
      SAL_E_IDLE:
      begin
        tck_d = 1'b0;
        div_d = 8'h00;
        if (start_i)
        begin
          kind_d = kind_i;
          len_d  = len_i;
          sr_d   = data_i;
          st_d   = SAL_E_PRE;
          if (kind_i == SAL_K_RESET)
          begin
            tms_d = SAL_TMS_RESET[0];
            pre_d = SAL_TMS_RESET >> 1;
            cnt_d = {5'h00, SAL_TMS_RESET_N} - 8'h01;
          end
          else if (kind_i == SAL_K_IR)
          begin
            tms_d = SAL_TMS_TO_IR[0];
            pre_d = SAL_TMS_TO_IR >> 1;
            cnt_d = {5'h00, SAL_TMS_TO_IR_N} - 8'h01;
          end
          else
          begin
            tms_d = SAL_TMS_TO_DR[0];
            pre_d = SAL_TMS_TO_DR >> 1;
            cnt_d = {5'h00, SAL_TMS_TO_DR_N} - 8'h01;
          end
        end
      end
      SAL_E_PRE:
      begin
        if (fall)
        begin
          if (cnt_q != 8'h00)
          begin
            tms_d = pre_q[0];
            pre_d = pre_q >> 1;
            cnt_d = cnt_q - 8'h01;
          end
          else if (kind_q == SAL_K_RESET)
          begin
            st_d   = SAL_E_IDLE;
            done_d = 1'b1;
          end
          else
          begin
            st_d  = SAL_E_SHIFT;
            tdi_d = sr_q[0];
            tms_d = (len_q == 8'h01);
            cap_d = 1'b1;
            cnt_d = len_q - 8'h01;
          end
        end
      end
      SAL_E_SHIFT:
      begin
        if (fall)
        begin
          if (cnt_q == 8'h00)
          begin
            st_d  = SAL_E_POST;
            tms_d = 1'b1;
            tdi_d = 1'b0;
            cap_d = 1'b0;
            cnt_d = 8'h01;
          end
          else
          begin
            tdi_d = sr_q[0];
            tms_d = (cnt_q == 8'h01);
            cnt_d = cnt_q - 8'h01;
          end
        end
      end
      SAL_E_POST:
      begin
        if (fall)
        begin
          if (cnt_q != 8'h00)
          begin
            tms_d = 1'b0;
            cnt_d = 8'h00;
          end
          else
          begin
            st_d   = SAL_E_IDLE;
            done_d = 1'b1;
          end
        end
      end
      default:
        st_d = SAL_E_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    s1_q <= tdo_i;
    s2_q <= s1_q;
    s3_q <= s2_q;
    if (reset_i)
    begin
      st_q    <= SAL_E_IDLE;
      kind_q  <= SAL_K_RESET;
      div_q   <= 8'h00;
      cnt_q   <= 8'h00;
      len_q   <= 8'h00;
      pre_q   <= 6'h00;
      sr_q    <= '0;
      tck_q   <= 1'b0;
      tms_q   <= 1'b1;
      tdi_q   <= 1'b0;
      cap_q   <= 1'b0;
      done_q  <= 1'b0;
      tdo_f_q <= 1'b0;
    end
    else
    begin
      st_q    <= st_d;
      kind_q  <= kind_d;
      div_q   <= div_d;
      cnt_q   <= cnt_d;
      len_q   <= len_d;
      pre_q   <= pre_d;
      sr_q    <= sr_d;
      tck_q   <= tck_d;
      tms_q   <= tms_d;
      tdi_q   <= tdi_d;
      cap_q   <= cap_d;
      done_q  <= done_d;
      tdo_f_q <= tdo_f_d;
    end
  end

  assign busy_o = (st_q != SAL_E_IDLE);
  assign done_o = done_q;
  assign data_o = sr_q;
  assign tck_o  = tck_q;
  assign tms_o  = tms_q;
  assign tdi_o  = tdi_q;

endmodule // sal_jtag_engine
`default_nettype wire

// >>> sal_limit_ctrl.sv
// Boundary-scan controller that checks a converter input against two limits
// Operation
// - Safe idle row whenever converter is unused; loaded only as the last load of each test run, not after reset
// - Settle-assist optional; left low here
// - Only one negative comparator source selected
// - Differential amplifier never operated through scan
// - Lower limit expects low, upper expects high
// - Test pin input, pull-up off
// - Wait 200ns after converter enable
// - DAC at midpoint while sampling
// - First load preload, later loads extest
// - Five loads per limit in fixed order
// - Check comparator in row after precharge
// - Test clock fast enough for hold time
`timescale 1ns/100ps
`default_nettype none
module sal_limit_ctrl #(
  parameter int unsigned CHAIN_LEN  = sal_pkg::SAL_CHAIN_LEN,
  parameter int unsigned IR_LEN     = sal_pkg::SAL_IR_LEN,
  parameter logic [3:0]  IR_SAMPLE  = sal_pkg::SAL_IR_SAMPLE,
  parameter logic [3:0]  IR_EXTEST  = sal_pkg::SAL_IR_EXTEST,
  parameter logic [7:0]  TCK_HALF   = sal_pkg::SAL_TCK_HALF
) (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic [31:0]     rdata_o,
  output logic            tck_o,
  output logic            tms_o,
  output logic            tdi_o,
  input  wire logic       tdo_i
);
  import sal_pkg::*;

  // One chain load: all port cells zero, so every pin is an input, pull-up off
  function automatic logic [CHAIN_LEN-1:0] build_row(
    input logic       adc_on,
    input logic [9:0] dac,
    input logic [7:0] mux,
    input logic       hold,
    input logic       comparator_precharge_n_n
  );
    logic [CHAIN_LEN-1:0] r;
    r                                 = '0;
    r[SAL_BIT_CONVERTER_POWER_ON]                  = adc_on;
    r[SAL_BIT_DAC_LO +: 10]           = dac;
    r[SAL_BIT_EXTCH]                  = 1'b1;
    r[SAL_BIT_HOLD]                   = hold;
    r[SAL_BIT_MUX_LO +: 8]            = mux;
    r[SAL_BIT_PASS_GATE_ENABLE]                 = 1'b1;
    r[SAL_BIT_COMPARATOR_PRECHARGE_N]                  = comparator_precharge_n_n;
    // Negative select, ground, bandgap, amplifier, settle, switch-cap and
    // supply reference all stay zero: one negative source only
    return r;
  endfunction

  // Row number of the test table for a sequence step
  function automatic logic [3:0] row_of(input logic [3:0] step);
    if (step == SAL_SEQ_ROW1)
      return 4'h1;
    else if (step == SAL_SEQ_ROW2)
      return 4'h2;
    else
      return step - SAL_SEQ_ROW_OFS;
  endfunction

  sal_ctl_state_t st_q, st_d;
  logic [3:0]     step_q, step_d;
  logic [7:0]     wait_q, wait_d;
  logic [7:0]     chan_q, chan_d;
  logic [9:0]     lower_q, lower_d;
  logic [9:0]     upper_q, upper_d;
  logic           done_q, done_d;
  logic           low_ok_q, low_ok_d;
  logic           high_ok_q, high_ok_d;
  logic [31:0]    rdata_q, rdata_d;
  logic           eng_start;
  sal_kind_t      eng_kind;
  logic [7:0]     eng_len;
  logic [CHAIN_LEN-1:0] eng_data;
  logic [CHAIN_LEN-1:0] eng_out;
  logic           eng_busy;
  logic           eng_done;
  logic [3:0]     row;
  logic [9:0]     row_dac;
  logic           row_hold;
  logic           row_comparator_precharge_n;
  logic           busy;

  assign busy = (st_q != SAL_C_IDLE);

  // Row contents for the limit sequence
  always_comb
  begin
    row       = row_of(step_q);
    row_hold  = 1'b1;
    row_comparator_precharge_n = 1'b1;
    row_dac   = SAL_DAC_MID;
    if (row == 4'h2 || row == 4'h7)
      row_hold = 1'b0;
    if (row == 4'h4 || row == 4'h5)
      row_dac = lower_q;
    if (row == 4'h9 || row == 4'hA)
      row_dac = upper_q;
    if (row == 4'h5 || row == 4'hA)
      row_comparator_precharge_n = 1'b0;
  end

  // Command for the walker in each step
  always_comb
  begin
    eng_start = (st_q == SAL_C_ISSUE);
    eng_kind  = SAL_K_DR;
    eng_len   = CHAIN_LEN[7:0];
    eng_data  = build_row(1'b1, row_dac, chan_q, row_hold, row_comparator_precharge_n);
    if (step_q == SAL_SEQ_TRST)
    begin
      eng_kind = SAL_K_RESET;
      eng_data = '0;
    end
    else if (step_q == SAL_SEQ_IR_SAMP)
    begin
      eng_kind = SAL_K_IR;
      eng_len  = IR_LEN[7:0];
      eng_data = {{(CHAIN_LEN-4){1'b0}}, IR_SAMPLE};
    end
    else if (step_q == SAL_SEQ_IR_EXT)
    begin
      eng_kind = SAL_K_IR;
      eng_len  = IR_LEN[7:0];
      eng_data = {{(CHAIN_LEN-4){1'b0}}, IR_EXTEST};
    end
    else if (step_q == SAL_SEQ_IDLE_ROW)
      eng_data = build_row(1'b0, SAL_DAC_MID, SAL_MUX_IDLE, 1'b1, 1'b1);
  end

  // Sequencer and register file
  always_comb
  begin
    st_d      = st_q;
    step_d    = step_q;
    wait_d    = wait_q;
    chan_d    = chan_q;
    lower_d   = lower_q;
    upper_d   = upper_q;
    done_d    = done_q;
    low_ok_d  = low_ok_q;
    high_ok_d = high_ok_q;
    rdata_d   = 32'h0000_0000;
    // Limits and channel are frozen while a test runs
    if (wr_i && !busy)
    begin
      if (addr_i == SAL_ADDR_CHAN)
        chan_d = wdata_i[7:0];
      else if (addr_i == SAL_ADDR_LOWER)
        lower_d = wdata_i[9:0];
      else if (addr_i == SAL_ADDR_UPPER)
        upper_d = wdata_i[9:0];
      else if (addr_i == SAL_ADDR_CTRL && wdata_i[SAL_CTRL_START])
      begin
        st_d      = SAL_C_ISSUE;
        step_d    = SAL_SEQ_TRST;
        done_d    = 1'b0;
        low_ok_d  = 1'b0;
        high_ok_d = 1'b0;
      end
    end
    if (rd_i)
    begin
      if (addr_i == SAL_ADDR_CHAN)
        rdata_d[7:0] = chan_q;
      else if (addr_i == SAL_ADDR_LOWER)
        rdata_d[9:0] = lower_q;
      else if (addr_i == SAL_ADDR_UPPER)
        rdata_d[9:0] = upper_q;
      else if (addr_i == SAL_ADDR_STATUS)
      begin
        rdata_d[SAL_ST_BUSY]    = busy;
        rdata_d[SAL_ST_DONE]    = done_q;
        rdata_d[SAL_ST_LOW_OK]  = low_ok_q;
        rdata_d[SAL_ST_HIGH_OK] = high_ok_q;
        rdata_d[SAL_ST_PASS]    = done_q & low_ok_q & high_ok_q;
      end
    end
    case (st_q)
      SAL_C_IDLE:
        wait_d = 8'h00;
      SAL_C_ISSUE:
        st_d = SAL_C_BUSY;
      SAL_C_BUSY:
      begin
        if (eng_done)
        begin
          // Result of the precharge step is captured during the next load
          if (step_q == SAL_SEQ_CHK_LOW)
            low_ok_d = ~eng_out[SAL_BIT_COMP];
          if (step_q == SAL_SEQ_CHK_HIGH)
            high_ok_d = eng_out[SAL_BIT_COMP];
          if (step_q == SAL_SEQ_IDLE_ROW)
          begin
            st_d   = SAL_C_IDLE;
            done_d = 1'b1;
          end
          else if (step_q == SAL_SEQ_ROW2)
          begin
            st_d   = SAL_C_WAIT;
            step_d = SAL_SEQ_WAIT;
            wait_d = 8'h00;
          end
          else
          begin
            st_d   = SAL_C_ISSUE;
            step_d = step_q + 4'h1;
          end
        end
      end
      SAL_C_WAIT:
      begin
        // Converter was enabled by the last update; let its dummy run finish
        wait_d = wait_q + 8'h01;
        if (wait_q == SAL_ENABLE_CYC[7:0] - 8'h01)
        begin
          st_d   = SAL_C_ISSUE;
          step_d = step_q + 4'h1;
        end
      end
      default:
        st_d = SAL_C_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      st_q      <= SAL_C_IDLE;
      step_q    <= SAL_SEQ_TRST;
      wait_q    <= 8'h00;
      chan_q    <= SAL_MUX_RESET;
      lower_q   <= SAL_LOWER_RESET;
      upper_q   <= SAL_UPPER_RESET;
      done_q    <= 1'b0;
      low_ok_q  <= 1'b0;
      high_ok_q <= 1'b0;
      rdata_q   <= 32'h0000_0000;
    end
    else
    begin
      st_q      <= st_d;
      step_q    <= step_d;
      wait_q    <= wait_d;
      chan_q    <= chan_d;
      lower_q   <= lower_d;
      upper_q   <= upper_d;
      done_q    <= done_d;
      low_ok_q  <= low_ok_d;
      high_ok_q <= high_ok_d;
      rdata_q   <= rdata_d;
    end
  end

  assign rdata_o = rdata_q;

  // Test clock rate is set by TCK_HALF; it must stay fast enough for hold
  // Below five clocks the filtered data line lags and a stale bit is taken
  sal_jtag_engine #(
    .WIDTH (CHAIN_LEN),
    .HALF  (TCK_HALF)
  ) u_engine (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .start_i (eng_start),
    .kind_i  (eng_kind),
    .len_i   (eng_len),
    .data_i  (eng_data),
    .busy_o  (eng_busy),
    .done_o  (eng_done),
    .data_o  (eng_out),
    .tck_o   (tck_o),
    .tms_o   (tms_o),
    .tdi_o   (tdi_o),
    .tdo_i   (tdo_i)
  );

endmodule // sal_limit_ctrl
`default_nettype wire

// >>> sal_limit_ctrl_assertions.sv
// Port checker for the converter limit test controller
`timescale 1ns/100ps
`default_nettype none
module sal_limit_ctrl_assertions #(
  parameter logic [7:0] TCK_HALF = sal_pkg::SAL_TCK_HALF
) (
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        tck_o,
  input wire logic        tms_o,
  input wire logic        tdi_o,
  input wire logic        tdo_i
);
  import sal_pkg::*;
  logic [7:0] hi_q;
  logic [7:0] hi_d;
  logic       go_q;
  logic       go_d;
  // Counts test clock high cycles so the half period is checked exactly
  always_comb
  begin
    hi_d = tck_o ? hi_q + 8'h01 : 8'h00;
    go_d = go_q || (wr_i && addr_i == SAL_ADDR_CTRL && wdata_i[SAL_CTRL_START]);
  end
  always_ff @(posedge clk_i)
  begin
    hi_q <= reset_i ? 8'h00 : hi_d;
    go_q <= reset_i ? 1'b0 : go_d;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_start;
    wr_i && addr_i == SAL_ADDR_CTRL && wdata_i[SAL_CTRL_START];
  endsequence
  sequence s_status_rd;
    rd_i && addr_i == SAL_ADDR_STATUS;
  endsequence
  a_rdata_idle_zero: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data not zero outside a read answer");
  a_unmapped_zero: assert property (rd_i && addr_i == 8'h14 |=> rdata_o == 32'h0)
    else $error("unmapped read returned data");
  a_rdata_narrow: assert property (rdata_o[31:10] == 22'h0)
    else $error("read data upper bits set");
  a_pass_is_both: assert property (
    s_status_rd |=> rdata_o[SAL_ST_PASS] == (rdata_o[SAL_ST_DONE]
      && rdata_o[SAL_ST_LOW_OK] && rdata_o[SAL_ST_HIGH_OK]))
    else $error("pass bit disagrees with limit bits");
  a_busy_not_done: assert property (
    s_status_rd |=> !(rdata_o[SAL_ST_BUSY] && rdata_o[SAL_ST_DONE]))
    else $error("busy and done both set");
  a_tck_high_len: assert property ($fell(tck_o) |-> hi_q == TCK_HALF)
    else $error("test clock high time wrong");
  a_link_steady: assert property ($changed(tms_o) || $changed(tdi_o) |-> !tck_o)
    else $error("mode or data line moved while test clock high");
  a_reset_lines: assert property ($fell(reset_i) |-> tms_o && !tck_o && !tdi_o)
    else $error("link lines wrong after reset");
  a_no_early_tck: assert property (!go_q |-> !tck_o)
    else $error("test clock ran before any start");
  a_start_clocks: assert property (s_start |-> ##[1:40] tck_o)
    else $error("start did not clock the link");
endmodule // sal_limit_ctrl_assertions
bind sal_limit_ctrl sal_limit_ctrl_assertions #(.TCK_HALF(TCK_HALF)) u_chk (
  .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tck_o(tck_o),
  .tms_o(tms_o), .tdi_o(tdi_o), .tdo_i(tdo_i));
`default_nettype wire

// >>> sal_scan_dev.sv
// Behavioural device: test access port, boundary register, comparator
`timescale 1ns/100ps
`default_nettype none
module sal_scan_dev (
  input  wire logic       tck_i,
  input  wire logic       tms_i,
  input  wire logic       tdi_i,
  output logic            tdo_o,
  input  wire logic [9:0] vin_i
);
  import sal_pkg::*;
  // Next port state indexed by state and mode bit
  localparam logic [127:0] NXT = 128'h21FB_EDFD_CBCB_0A21_8476_8654_5493_2101;
  logic [3:0]   st = 4'h0;
  logic [3:0]   ir = 4'hF;
  logic [3:0]   ir_sr = 4'h0;
  logic [197:0] sr = '0;
  logic [197:0] upd_q = '0;
  logic         comp_q = 1'b0;
  logic         on_q = 1'b0;
  logic [7:0]   last_mux = 8'h00;
  int           rows = 0;
  int           faults = 0;
  realtime      t_en = 0.0;
  task automatic upd(input logic [197:0] r);
    if ((rows % 12 == 0) !== (ir == SAL_IR_SAMPLE)) faults++;
    if (r[161] !== 1'b1 || r[164:162] !== 3'h0) faults++;
    if (r[197:189] !== 9'h0 || r[187] !== 1'b0 || r[175] !== 1'b0) faults++;
    if (r[159:158] !== 2'h0 || r[157:0] !== '0) faults++;
    if (!r[174] && r[186:177] !== SAL_DAC_MID) faults++;
    if (!$onehot(r[172:165])) faults++;
    if (ir == SAL_IR_EXTEST)
    begin
      if (r[188] && !on_q) t_en = $realtime;
      else if (r[188] && $realtime - t_en < 200.0) faults++;
      on_q = r[188];
      // Latch resolves only while precharge is low
      if (!r[160]) comp_q = r[186:177] > vin_i;
      if (r[188]) last_mux = r[172:165];
    end
    upd_q = r;
    rows++;
  endtask
  // Outside a shift the line is released, so it shows a changing value
  always @(negedge tck_i)
    tdo_o <= (st == 4'h4) ? sr[0] : (st == 4'hB) ? ir_sr[0] : ~tdo_o;
  always @(posedge tck_i)
  begin
    st <= NXT[{st, tms_i, 2'b00} +: 4];
    case (st)
      4'h0: ir <= 4'hF;
      4'h3: sr <= {upd_q[197:194], comp_q, upd_q[192:0]};
      4'h4: sr <= {tdi_i, sr[197:1]};
      4'h8: upd(sr);
      4'hA: ir_sr <= 4'h1;
      4'hB: ir_sr <= {tdi_i, ir_sr[3:1]};
      4'hF: ir <= ir_sr;
      default: ;
    endcase
  end
endmodule // sal_scan_dev
`default_nettype wire

// >>> sal_limit_ctrl_tb.sv
// Self-checking bench for the converter limit test controller
`timescale 1ns/100ps
`default_nettype none
module sal_limit_ctrl_tb;
  import sal_pkg::*;
  logic        clk_i   = 1'b0;
  logic        reset_i = 1'b1;
  logic [7:0]  addr_i  = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i    = 1'b0;
  logic        rd_i    = 1'b0;
  logic [31:0] rdata_o;
  logic        tck_o;
  logic        tms_o;
  logic        tdi_o;
  logic        tdo_i;
  logic [9:0]  vin     = 10'h000;
  logic [31:0] rv;
  int          bad_count = 0;
  int          samples_checked = 0;
  // Five clocks is the shortest half period the three-stage pin filter allows
  sal_limit_ctrl #(.TCK_HALF(8'h05)) uut (.clk_i(clk_i), .reset_i(reset_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .tck_o(tck_o), .tms_o(tms_o), .tdi_o(tdi_o), .tdo_i(tdo_i));
  sal_scan_dev dev (.tck_i(tck_o), .tms_i(tms_o), .tdi_i(tdi_o), .tdo_o(tdo_i),
    .vin_i(vin));
  initial
  begin
    forever #25 clk_i = ~clk_i;
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    rv = rdata_o;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string n);
    rd(a);
    chk(n, e, rv);
  endtask
  task automatic run_one(input logic [9:0] v, input logic [7:0] ch, input logic [31:0] e);
    int n;
    n = 0;
    vin <= v;
    wr(SAL_ADDR_CHAN, {24'h0, ch});
    wr(SAL_ADDR_CTRL, 32'h1);
    rdc(SAL_ADDR_STATUS, 32'h1, "status busy");
    wr(SAL_ADDR_CHAN, 32'h40);
    rdc(SAL_ADDR_CHAN, {24'h0, ch}, "chan held");
    rv = 32'h1;
    while (rv[SAL_ST_BUSY] === 1'b1 && n < 20000)
    begin
      rd(SAL_ADDR_STATUS);
      n++;
    end
    chk("status end", e, rv);
    chk("row channel", {24'h0, ch}, {24'h0, dev.last_mux});
  endtask
  initial
  begin
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    rdc(SAL_ADDR_CHAN, 32'h08, "chan reset");
    rdc(SAL_ADDR_LOWER, 32'h0, "lower reset");
    rdc(SAL_ADDR_UPPER, 32'h3FF, "upper reset");
    rdc(SAL_ADDR_STATUS, 32'h0, "status reset");
    rdc(SAL_ADDR_CTRL, 32'h0, "ctrl read");
    wr(8'h14, 32'hFFFF_FFFF);
    rdc(8'h14, 32'h0, "unmapped read");
    wr(SAL_ADDR_LOWER, 32'h123);
    wr(SAL_ADDR_UPPER, 32'h143);
    rdc(SAL_ADDR_LOWER, 32'h123, "lower");
    run_one(10'h130, 8'h08, 32'h1E);
    run_one(10'h143, 8'h20, 32'h06);
    run_one(10'h100, 8'h01, 32'h0A);
    chk("row count", 32'd36, 32'(dev.rows));
    chk("idle row", {11'h0, 1'b0, SAL_MUX_IDLE, SAL_DAC_MID, 1'b1, 1'b1},
      {11'h0, dev.upd_q[188], dev.upd_q[172:165], dev.upd_q[186:177],
       dev.upd_q[174], dev.upd_q[160]});
    chk("device faults", 32'h0, 32'(dev.faults));
    give_verdict();
  end
  initial
  begin
    // Three runs need about 74k clocks; this leaves a margin of about 11k
    #4250000;
    bad_count++;
    give_verdict();
  end
endmodule // sal_limit_ctrl_tb
`default_nettype wire
